// [hdl/fels_device.sv]
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "fels_defs.svh"
module fels_device
  import fels_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `FELS_ERASE_CYC,
  parameter int unsigned PROG_CYC  = `FELS_PROG_CYC,
  parameter int unsigned LOCK_CYC  = `FELS_LOCK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  fels_if.dev              link,
  input  wire logic        arr_fail,
  input  wire logic [15:0] arr_rdata,
  output fels_op_e         arr_op,
  output logic [3:0]       arr_blk,
  output logic [19:0]      arr_addr,
  output logic [15:0]      arr_wdata
);
  // ****************************************
  // State and helpers
  // ****************************************
  fels_dev_s   s_reg;        // Registered state
  fels_dev_s   s_next;       // Next state
  logic [7:0]  code_in;      // Decoded low byte
  logic [3:0]  blk_in;       // Block of link address
  logic        blk_ok;       // Block index exists
  logic        top_addr;     // Address is block top
  logic [7:0]  status_byte;  // Assembled status
  logic        err_any;      // Either error set

  // Protection of a block, lock bits kept as stored
  function automatic logic locked(input logic [13:0] lk, input logic [3:0] b,
                                  input logic dis);
    locked = !dis && !lk[b];
  endfunction

  assign code_in  = link.wdata[7:0];
  assign blk_in   = link.addr[`FELS_BLK_MSB:`FELS_BLK_LSB];
  assign blk_ok   = (blk_in < 4'(`FELS_NUM_BLK));
  assign top_addr = &link.addr[`FELS_BLK_LSB-1:1];
  assign err_any  = s_reg.err_e | s_reg.err_p;

  // ****************************************
  // Status byte
  // ****************************************
  always_comb begin
    status_byte = 8'h00;                            // Reserved bits zero
    status_byte[`FELS_SR_READY_BIT] = s_reg.ready;
    status_byte[`FELS_SR_ERASE_BIT] = s_reg.err_e;
    status_byte[`FELS_SR_PROG_BIT]  = s_reg.err_p;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    // Read answer one cycle after the strobe
    if (link.rd) begin
      s_next.rvalid = 1'b1;
      if (link.ram_mode && s_reg.status_mode) begin
        s_next.rdata = {8'h00, status_byte};
      end else begin
        s_next.rdata = arr_rdata;
      end
    end
    case (s_reg.state)
      // First bus cycle of a command
      FELS_IDLE: begin
        if (link.wr) begin
          s_next.code  = code_in;
          s_next.addr1 = link.addr;
          case (code_in)
            `FELS_CMD_READ_ARRAY: begin
              s_next.status_mode = 1'b0;
            end
            `FELS_CMD_READ_STATUS: begin
              s_next.status_mode = 1'b1;
            end
            `FELS_CMD_CLEAR_STATUS: begin
              s_next.err_e = 1'b0;
              s_next.err_p = 1'b0;
            end
            `FELS_CMD_PROGRAM, `FELS_CMD_BLOCK_ERASE,
            `FELS_CMD_ERASE_ALL, `FELS_CMD_LOCK_PROG: begin
              // Refused while an error stands
              if (!err_any) begin
                s_next.state = FELS_ARG;
              end
            end
            `FELS_CMD_LOCK_READ: begin
              s_next.state = FELS_ARG;
            end
            default: begin
              s_next.err_e = 1'b1;
              s_next.err_p = 1'b1;
            end
          endcase
        end
      end
      // Second bus cycle of a command
      FELS_ARG: begin
        if (link.wr) begin
          s_next.state = FELS_IDLE;
          s_next.blk   = blk_in;
          s_next.wdata = link.wdata;
          if (s_reg.code == `FELS_CMD_PROGRAM) begin
            if (link.addr != s_reg.addr1 || !blk_ok) begin
              s_next.err_e = 1'b1;
              s_next.err_p = 1'b1;
            end else if (locked(s_reg.lock, blk_in, link.lfd)) begin
              s_next.err_p = 1'b1;
            end else begin
              s_next.state = FELS_BUSY;
              s_next.ready = 1'b0;
              s_next.cnt   = 16'(PROG_CYC);
              s_next.op    = FELS_OP_PROG;
              s_next.status_mode = 1'b1;
            end
          end else if (code_in == `FELS_CMD_READ_ARRAY) begin
            s_next.status_mode = 1'b0;
          end else if (code_in != `FELS_CMD_CONFIRM) begin
            s_next.err_e = 1'b1;
            s_next.err_p = 1'b1;
          end else if (s_reg.code == `FELS_CMD_ERASE_ALL) begin
            s_next.state = FELS_BUSY;
            s_next.ready = 1'b0;
            s_next.blk   = 4'h0;
            s_next.cnt   = locked(s_reg.lock, 4'h0, link.lfd) ? 16'h0000 : 16'(ERASE_CYC);
            s_next.op    = FELS_OP_ERASE;
            s_next.status_mode = 1'b1;
          end else if (!blk_ok || !top_addr) begin
            s_next.err_e = 1'b1;
            s_next.err_p = 1'b1;
          end else if (s_reg.code == `FELS_CMD_BLOCK_ERASE) begin
            if (locked(s_reg.lock, blk_in, link.lfd)) begin
              s_next.err_e = 1'b1;
            end else begin
              s_next.state = FELS_BUSY;
              s_next.ready = 1'b0;
              s_next.cnt   = 16'(ERASE_CYC);
              s_next.op    = FELS_OP_ERASE;
              s_next.status_mode = 1'b1;
            end
          end else if (s_reg.code == `FELS_CMD_LOCK_PROG) begin
            if (link.addr != s_reg.addr1) begin
              s_next.err_e = 1'b1;
              s_next.err_p = 1'b1;
            end else begin
              s_next.state = FELS_BUSY;
              s_next.ready = 1'b0;
              s_next.cnt   = 16'(LOCK_CYC);
              s_next.op    = FELS_OP_LOCK;
              s_next.status_mode = 1'b1;
            end
          end else begin
            // Lock status read: one busy cycle
            s_next.state = FELS_BUSY;
            s_next.ready = 1'b0;
            s_next.cnt   = 16'h0000;
            s_next.op    = FELS_OP_NONE;
            s_next.status_mode = 1'b0;
          end
        end
      end
      // Operation running
      FELS_BUSY: begin
        if (s_reg.cnt != 16'h0000) begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end else begin
          s_next.state = FELS_IDLE;
          s_next.ready = 1'b1;
          s_next.op    = FELS_OP_NONE;
          case (s_reg.code)
            `FELS_CMD_PROGRAM: begin
              if (arr_fail) s_next.err_p = 1'b1;
            end
            `FELS_CMD_BLOCK_ERASE: begin
              if (arr_fail) s_next.err_e = 1'b1;
              else s_next.lock[s_reg.blk] = 1'b1;
            end
            `FELS_CMD_ERASE_ALL: begin
              if (!locked(s_reg.lock, s_reg.blk, link.lfd)) begin
                if (arr_fail) s_next.err_e = 1'b1;
                else s_next.lock[s_reg.blk] = 1'b1;
              end
              // Walk on up to block 12 only, block A never
              if (s_reg.blk != 4'(`FELS_ALL_LAST)) begin
                s_next.state = FELS_BUSY;
                s_next.ready = 1'b0;
                s_next.op    = FELS_OP_ERASE;
                s_next.blk   = s_reg.blk + 4'h1;
                s_next.cnt   = locked(s_reg.lock, s_reg.blk + 4'h1, link.lfd)
                               ? 16'h0000 : 16'(ERASE_CYC);
              end
            end
            `FELS_CMD_LOCK_PROG: begin
              if (arr_fail) s_next.err_p = 1'b1;
              else s_next.lock[s_reg.blk] = 1'b0;
            end
            default: begin
              s_next.lsr = s_reg.lock[s_reg.blk];
            end
          endcase
        end
      end
      default: begin
        s_next.state = FELS_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg             <= '0;
      s_reg.state       <= FELS_IDLE;
      s_reg.ready       <= `FELS_READY_RST;
      s_reg.err_e       <= `FELS_ERR_RST;
      s_reg.err_p       <= `FELS_ERR_RST;
      s_reg.lock        <= '1;  // Blocks start unlocked
      s_reg.op          <= FELS_OP_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.ready  = s_reg.ready;
  assign link.err_e  = s_reg.err_e;
  assign link.err_p  = s_reg.err_p;
  assign link.lsr    = s_reg.lsr;
  assign link.rdata  = s_reg.rdata;
  assign link.rvalid = s_reg.rvalid;
  assign arr_op      = s_reg.op;
  assign arr_blk     = s_reg.blk;
  assign arr_addr    = s_reg.addr1;
  assign arr_wdata   = s_reg.wdata;
endmodule
`default_nettype wire

// [include/fels_defs.svh]
`ifndef FELS_DEFS_SVH
`define FELS_DEFS_SVH
// ****************************************
// Command codes (low byte of the word)
// ****************************************
`define FELS_CMD_READ_ARRAY   8'hFF
`define FELS_CMD_READ_STATUS  8'h70
`define FELS_CMD_CLEAR_STATUS 8'h50
`define FELS_CMD_PROGRAM      8'h40
`define FELS_CMD_BLOCK_ERASE  8'h20
`define FELS_CMD_ERASE_ALL    8'hA7
`define FELS_CMD_LOCK_PROG    8'h77
`define FELS_CMD_LOCK_READ    8'h71
`define FELS_CMD_CONFIRM      8'hD0
// ****************************************
// Status byte fields and reset values
// ****************************************
`define FELS_SR_READY_BIT     7
`define FELS_SR_ERASE_BIT     5
`define FELS_SR_PROG_BIT      4
`define FELS_READY_RST        1'b1
`define FELS_ERR_RST          1'b0
// ****************************************
// Address layout of the user area
// ****************************************
`define FELS_ADDR_W           20
`define FELS_BLK_MSB          19
`define FELS_BLK_LSB          16
`define FELS_NUM_BLK          14
`define FELS_BLK_A            13
`define FELS_ALL_LAST         12
// ****************************************
// Operation times
// ****************************************
`define FELS_CLK_NS           5
`define FELS_ERASE_NS         2000
`define FELS_PROG_NS          200
`define FELS_LOCK_NS          100
`define FELS_ERASE_CYC        (`FELS_ERASE_NS / `FELS_CLK_NS)
`define FELS_PROG_CYC         (`FELS_PROG_NS / `FELS_CLK_NS)
`define FELS_LOCK_CYC         (`FELS_LOCK_NS / `FELS_CLK_NS)
// ****************************************
// Controller registers on APB
// ****************************************
`define FELS_REG_ADDR         12'h000
`define FELS_REG_CMD          12'h004
`define FELS_REG_READ         12'h008
`define FELS_REG_RDATA        12'h00C
`define FELS_REG_MODE         12'h010
`define FELS_REG_STAT         12'h014
`define FELS_MODE_RAM_BIT     0
`define FELS_MODE_FLASH_BIT   1
`define FELS_MODE_LFD_BIT     2
`define FELS_MODE_RST         3'h0
`define FELS_GUARD_BLK        4'h0
`endif

// [include/fels_pkg.sv]
// ****************************************
// Types of the erase/lock sequencer
// ****************************************
package fels_pkg;
  // Sequencer states, Gray along idle, argument, busy
  typedef enum logic [1:0] {
    FELS_IDLE = 2'b00,
    FELS_ARG  = 2'b01,
    FELS_BUSY = 2'b11
  } fels_state_e;

  // Array operation shown to the array side
  typedef enum logic [1:0] {
    FELS_OP_NONE  = 2'b00,
    FELS_OP_ERASE = 2'b01,
    FELS_OP_PROG  = 2'b11,
    FELS_OP_LOCK  = 2'b10
  } fels_op_e;

  // Whole device state
  typedef struct packed {
    fels_state_e  state;
    logic [7:0]   code;
    logic [19:0]  addr1;
    logic [3:0]   blk;
    logic [15:0]  cnt;
    logic [15:0]  wdata;
    logic         ready;
    logic         err_e;
    logic         err_p;
    logic         lsr;
    logic         status_mode;
    logic [13:0]  lock;
    logic [15:0]  rdata;
    logic         rvalid;
    fels_op_e     op;
  } fels_dev_s;

  // Whole controller state
  typedef struct packed {
    logic [19:0]  addr;
    logic [2:0]   mode;
    logic [15:0]  rdata;
    logic [7:0]   last_code;
    logic         wr;
    logic         rd;
    logic [15:0]  wdata;
  } fels_host_s;
endpackage

// [include/fels_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Command link between CPU side and flash
// ****************************************
interface fels_if;
  logic        wr;      // Command write strobe
  logic        rd;      // Read strobe
  logic [19:0] addr;    // Even user-area address
  logic [15:0] wdata;   // Command or data word
  logic [15:0] rdata;   // Read answer
  logic        rvalid;  // Read answer valid
  logic        ram_mode;
  logic        flash_mode;
  logic        lfd;     // Lock function disable
  logic        ready;   // Sequencer ready flag
  logic        err_e;   // Erase error flag
  logic        err_p;   // Program error flag
  logic        lsr;     // Lock status result

  modport dev  (input wr, rd, addr, wdata, ram_mode, flash_mode, lfd,
                output rdata, rvalid, ready, err_e, err_p, lsr);
  modport host (output wr, rd, addr, wdata, ram_mode, flash_mode, lfd,
                input rdata, rvalid, ready, err_e, err_p, lsr);
endinterface
`default_nettype wire

// [hdl/fels_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fels_defs.svh"
// ****************************************
// APB controller issuing command words
// ****************************************
module fels_host
  import fels_pkg::*;
#(
  parameter logic [3:0] GUARD_BLK = `FELS_GUARD_BLK
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  fels_if.host             link
);
  // ****************************************
  // State and decode
  // ****************************************
  fels_host_s  h_reg;     // Registered state
  fels_host_s  h_next;    // Next state
  logic        acc;       // APB access phase
  logic        wr_acc;    // Write access
  logic        refuse;    // Command held back
  logic        mapped;    // Known offset
  logic        fmode;     // Flash-execution mode

  assign acc    = psel & penable;
  assign wr_acc = acc & pwrite;
  assign fmode  = h_reg.mode[`FELS_MODE_FLASH_BIT];
  assign mapped = (paddr == `FELS_REG_ADDR) || (paddr == `FELS_REG_CMD) ||
                  (paddr == `FELS_REG_READ) || (paddr == `FELS_REG_RDATA) ||
                  (paddr == `FELS_REG_MODE) || (paddr == `FELS_REG_STAT);

  // Guard for flash-execution rewrites
  always_comb begin
    refuse = 1'b0;
    if (fmode && pwdata[7:0] == `FELS_CMD_ERASE_ALL &&
        h_reg.mode[`FELS_MODE_LFD_BIT]) begin
      refuse = 1'b1;
    end
    if (fmode && h_reg.addr[`FELS_BLK_MSB:`FELS_BLK_LSB] == GUARD_BLK &&
        (h_reg.last_code == `FELS_CMD_PROGRAM ||
         h_reg.last_code == `FELS_CMD_BLOCK_ERASE)) begin
      refuse = 1'b1;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    h_next    = h_reg;
    h_next.wr = 1'b0;
    h_next.rd = 1'b0;
    if (link.rvalid) begin
      h_next.rdata = link.rdata;
    end
    if (wr_acc) begin
      case (paddr)
        `FELS_REG_ADDR: begin
          h_next.addr = {pwdata[19:1], 1'b0};
        end
        `FELS_REG_CMD: begin
          if (!refuse) begin
            h_next.wr    = 1'b1;
            h_next.wdata = pwdata[15:0];
            h_next.last_code = pwdata[7:0];
          end
        end
        `FELS_REG_READ: begin
          h_next.rd = 1'b1;
        end
        `FELS_REG_MODE: begin
          h_next.mode = pwdata[2:0];
        end
        default: begin
          h_next.mode = h_reg.mode;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      h_reg      <= '0;
      h_reg.mode <= `FELS_MODE_RST;
    end else begin
      h_reg <= h_next;
    end
  end

  // ****************************************
  // APB answer, zero wait states
  // ****************************************
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `FELS_REG_ADDR:  prdata = {12'h000, h_reg.addr};
      `FELS_REG_RDATA: prdata = {16'h0000, h_reg.rdata};
      `FELS_REG_MODE:  prdata = {29'h0000_0000, h_reg.mode};
      `FELS_REG_STAT:  prdata = {27'h000_0000, link.lsr, link.err_p,
                                 link.err_e, link.ready, h_reg.rd};
      default:         prdata = 32'h0000_0000;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = acc & (!mapped | (pwrite & paddr == `FELS_REG_CMD & refuse));

  // ****************************************
  // Link drive
  // ****************************************
  assign link.wr         = h_reg.wr;
  assign link.rd         = h_reg.rd;
  assign link.addr       = h_reg.addr;
  assign link.wdata      = h_reg.wdata;
  assign link.ram_mode   = h_reg.mode[`FELS_MODE_RAM_BIT];
  assign link.flash_mode = fmode;
  assign link.lfd        = h_reg.mode[`FELS_MODE_LFD_BIT];
endmodule
`default_nettype wire

// [test/fels_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// *****
// Link checks between host and device
// *****
module fels_asserts (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        ram_mode,
  input wire logic        ready,
  input wire logic        err_e,
  input wire logic        err_p,
  input wire logic        lsr
);
  localparam int BUSY_MAX = 200; // Longest busy with short counts
  logic       pend;                // First word of a pair taken
  logic [7:0] pcode;               // Code of that first word
  wire  [7:0] code = wdata[7:0];   // Decoded low byte
  wire        err  = err_e | err_p;
  wire        clr  = wr && ready && !pend && code == 8'h50;

  // Follow the first word of two-word commands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend  <= 1'b0;
      pcode <= 8'h00;
    end else if (wr && ready) begin
      pend <= !pend && (code == 8'h71 || (!err && code inside {8'h20, 8'hA7, 8'h77, 8'h40}));
      if (!pend) begin
        pcode <= code;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence pair_second;
    wr && ready && pend && pcode inside {8'h20, 8'hA7, 8'h77};
  endsequence
  sequence bad_second;
    pair_second ##0 !(code inside {8'hD0, 8'hFF});
  endsequence

  rd_answer_a: assert property (rd |=> rvalid)
    else $error("read not answered");
  busy_status_a: assert property (rvalid && ram_mode && pcode != 8'h71 && !ready && !$past(ready) |-> !rdata[7])
    else $error("status byte not busy");
  ready_cause_a: assert property ($fell(ready) |-> $past(wr))
    else $error("busy without command");
  busy_bound_a: assert property ($fell(ready) |-> ##[1:BUSY_MAX] ready)
    else $error("busy too long");
  err_clear_a: assert property ($fell(err_e) || $fell(err_p) |-> $past(clr))
    else $error("error flag fell without clear");
  err_refuse_a: assert property (wr && ready && !pend && err && code inside {8'h20, 8'hA7, 8'h77, 8'h40} |=> ready [*3])
    else $error("command taken with error set");
  seq_error_a: assert property (bad_second |=> err_e && err_p)
    else $error("bad second word not flagged");
  cancel_idle_a: assert property (pair_second ##0 code == 8'hFF |=> (ready && !err) [*3])
    else $error("cancel did not return idle");
  reset_flags_a: assert property ($rose(reset_n) |-> ready && !err && !lsr)
    else $error("flags wrong after reset");
  lsr_update_a: assert property ($changed(lsr) |-> !ready || !$past(ready))
    else $error("lock result changed when idle");
  err_cause_a: assert property ($rose(err) |-> $past(wr) || !$past(ready))
    else $error("error rose without cause");
endmodule
`default_nettype wire

// [test/test_flash_erase_lock_status_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fels_defs.svh"
// *****
// Bench: APB commands through host into device
// *****
module test_flash_erase_lock_status_sequencer;
  import fels_pkg::*;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;       // APB offset
  logic [31:0] pwdata, prdata, rd_v;
  logic        arr_fail;    // Array verify result
  logic [15:0] arr_rdata;   // Array read word
  logic        er_v, lsr_x; // Last slave error, expected lock result
  logic [3:0]  b;           // Block under test
  fels_op_e    arr_op_v;    // Array operation shown
  logic [3:0]  arr_blk_v;   // Array block shown
  logic [19:0] arr_addr_v;  // Array address shown
  int          miscompares, n_checks, seed;

  fels_if link ();
  fels_host fels_host_i (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  fels_device #(.ERASE_CYC(4), .PROG_CYC(2), .LOCK_CYC(1)) fels_device_i (.clk_sys,
    .reset_n, .link(link), .arr_fail, .arr_rdata, .arr_op(arr_op_v), .arr_blk(arr_blk_v),
    .arr_addr(arr_addr_v), .arr_wdata());
  fels_asserts fels_asserts_i (.clk_sys, .reset_n, .wr(link.wr), .rd(link.rd),
    .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid), .ram_mode(link.ram_mode),
    .ready(link.ready), .err_e(link.err_e), .err_p(link.err_p), .lsr(link.lsr));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare a result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Expected controller status word
  function automatic logic [31:0] st(input logic e, input logic p);
    return {27'h0, lsr_x, p, e, 1'b1, 1'b0};
  endfunction

  // Command word to top word of block k, random upper byte
  task automatic cmd(input logic [3:0] k, input logic [7:0] c);
    apb(1'b1, `FELS_REG_ADDR, {12'h000, k, 16'hFFFE});
    apb(1'b1, `FELS_REG_CMD, {16'h0000, 8'($random(seed)), c});
  endtask

  // Poll until ready; status left in rd_v
  task automatic idle();
    repeat (2) @(posedge clk_sys);
    do apb(1'b0, `FELS_REG_STAT, 32'h0); while (rd_v[1] !== 1'b1);
  endtask

  // Read one word over the link into rd_v
  task automatic rdw();
    apb(1'b1, `FELS_REG_READ, 32'h0);
    repeat (3) @(posedge clk_sys);
    do apb(1'b0, `FELS_REG_STAT, 32'h0); while (rd_v[0] !== 1'b0);
    apb(1'b0, `FELS_REG_RDATA, 32'h0);
  endtask

  // Command (second word 00 means none), then status check
  task automatic op(input logic [7:0] c, input logic [7:0] c2, input logic [3:0] k,
                    input logic e, input logic p);
    cmd(k, c);
    if (c2 != 8'h00) begin
      cmd(k, c2);
    end
    idle();
    chk(rd_v, st(e, p), "status after command");
    $display("test %h %h blk %0d done", c, c2, k);
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  // Main sequence
  initial begin
    seed = 32'h80EB9465;
    {psel, penable, pwrite, arr_fail, lsr_x} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    arr_rdata = 16'h0000;
    reset_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, `FELS_REG_STAT, 32'h0);
    chk(rd_v, st(1'b0, 1'b0), "reset status");
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, er_v}, 32'h1, "unmapped offset");
    b = 4'($unsigned($random(seed)) % 13);
    op(8'h77, 8'hD0, b, 1'b0, 1'b0);
    op(8'h71, 8'hD0, b, 1'b0, 1'b0);
    op(8'h20, 8'hD0, b, 1'b1, 1'b0);
    op(8'h20, 8'h00, b, 1'b1, 1'b0);
    op(8'hA7, 8'h00, b, 1'b1, 1'b0);
    op(8'h77, 8'h00, b, 1'b1, 1'b0);
    op(8'h50, 8'h00, b, 1'b0, 1'b0);
    apb(1'b1, `FELS_REG_MODE, 32'h4);
    op(8'h71, 8'hD0, b, 1'b0, 1'b0);
    op(8'h20, 8'hD0, b, 1'b0, 1'b0);
    lsr_x = 1'b1;
    op(8'h71, 8'hD0, b, 1'b0, 1'b0);
    op(8'h77, 8'hD0, 4'hC, 1'b0, 1'b0);
    op(8'h77, 8'hD0, 4'hD, 1'b0, 1'b0);
    op(8'hA7, 8'hD0, 4'h0, 1'b0, 1'b0);
    op(8'h71, 8'hD0, 4'hC, 1'b0, 1'b0);
    lsr_x = 1'b0;
    op(8'h71, 8'hD0, 4'hD, 1'b0, 1'b0);
    apb(1'b1, `FELS_REG_MODE, 32'h0);
    op(8'h20, 8'h33, b, 1'b1, 1'b1);
    op(8'h50, 8'h00, b, 1'b0, 1'b0);
    op(8'h20, 8'hFF, b, 1'b0, 1'b0);
    op(8'h40, 8'h5A, b, 1'b0, 1'b0);
    arr_fail <= 1'b1;
    op(8'h40, 8'hA5, b, 1'b0, 1'b1);
    op(8'h50, 8'h00, b, 1'b0, 1'b0);
    op(8'h20, 8'hD0, b, 1'b1, 1'b0);
    op(8'h50, 8'h00, b, 1'b0, 1'b0);
    op(8'h77, 8'hD0, b, 1'b0, 1'b1);
    op(8'h50, 8'h00, b, 1'b0, 1'b0);
    arr_fail <= 1'b0;
    apb(1'b1, `FELS_REG_MODE, 32'h2);
    cmd(4'h0, 8'h20);
    cmd(4'h0, 8'hD0);
    chk({31'h0, er_v}, 32'h1, "guarded block refused");
    cmd(4'h5, 8'hFF);
    apb(1'b1, `FELS_REG_MODE, 32'h6);
    cmd(b, 8'hA7);
    chk({31'h0, er_v}, 32'h1, "erase-all refused");
    apb(1'b1, `FELS_REG_MODE, 32'h5);
    cmd(b, 8'h20);
    cmd(b, 8'hD0);
    apb(1'b1, `FELS_REG_READ, 32'h0);
    chk({10'h0, arr_blk_v, arr_addr_v[15:0], arr_op_v},
        {10'h0, b, 16'hFFFE, 2'b01}, "array op");
    idle();
    rdw();
    chk({24'h0, rd_v[7:0]}, 32'h80, "status byte");
    cmd(b, 8'hFF);
    arr_rdata <= 16'($random(seed));
    rdw();
    chk(rd_v[15:0], {16'h0, arr_rdata}, "array word");
    cmd(b, 8'h70);
    rdw();
    chk({24'h0, rd_v[7:0]}, 32'h80, "status after read status");
    $display("test ram mode reads done");
    summarize();
  end
endmodule
`default_nettype wire
